// ==== core/gain_loop_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the gain loop.
`ifndef GAIN_LOOP_REGS_SVH
`define GAIN_LOOP_REGS_SVH

// Register offsets on the register port.
`define TARGET_ADDR         6'h1B
`define ABS_THR_ADDR        6'h1C
`define GAIN_CTRL_ADDR      6'h1D
`define MANUAL_GAIN_ADDR    6'h2F

// Field positions.
`define HYST_FIELD          7:6
`define WAIT_FIELD          5:4
`define HOLD_FIELD          3:2
`define FILT_FIELD          1:0
`define THR_FIELD           3:0
`define TARGET_FIELD        2:0
`define MAN_ANALOG_FIELD    5:3
`define MAN_DIGITAL_FIELD   2:0

// Reset values.
`define GAIN_CTRL_RESET     8'h91
`define ABS_THR_RESET       4'h0
`define TARGET_RESET        3'h3
`define MANUAL_GAIN_RESET   6'h00

// Absolute threshold code that switches the criterion off.
`define THR_DISABLED        4'h8

// Gain hold codes.
`define HOLD_NONE           2'h0
`define HOLD_ON_SYNC        2'h1
`define HOLD_ANALOG         2'h2
`define HOLD_ALL            2'h3

// Averaging and waiting in channel filter samples.
`define AVG_BASE_LOG2       3
`define WAIT_UNIT_SAMPLES   6'h08

// Amplitude target in dB per target code.
`define TARGET_DB_0         8'h18
`define TARGET_DB_1         8'h1B
`define TARGET_DB_2         8'h1E
`define TARGET_DB_3         8'h21
`define TARGET_DB_4         8'h24
`define TARGET_DB_5         8'h26
`define TARGET_DB_6         8'h28
`define TARGET_DB_7         8'h2A

// Dead zone limits in dB above (UP) and below (DN) the target per hysteresis code.
`define DZ_UP_0             10'h001
`define DZ_DN_0             10'h001
`define DZ_UP_1             10'h002
`define DZ_DN_1             10'h001
`define DZ_UP_2             10'h003
`define DZ_DN_2             10'h002
`define DZ_UP_3             10'h005
`define DZ_DN_3             10'h003

// Extra margin before the loop reverses direction, and gain per reduction step.
`define REVERSAL_MARGIN_DB  10'h001
`define GAIN_STEP_DB        4'h3
`define GAIN_MAX_STEP       3'h7
`define GAIN_MIN_STEP       3'h0

`endif

// ==== core/gain_loop_pkg.sv ====
// Types shared by the gain loop modules.
package gain_loop_pkg;

   typedef enum logic [1:0] {
      DIR_NONE,
      DIR_DOWN,
      DIR_UP
   } step_dir_t;

   typedef enum logic [0:0] {
      ST_ACCUM,
      ST_WAIT
   } loop_state_t;

   typedef struct packed {
      logic [13:0] sum;
      logic [6:0]  count;
      logic [7:0]  average;
      logic        valid;
   } averager_state_t;

endpackage

// ==== core/sample_averager.sv ====
// Running block average of channel filter amplitude samples.
`timescale 1ns/10ps
`include "gain_loop_regs.svh"

module sample_averager
(
   // Clock and reset.
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   // Control.
   input  wire logic       clear_in,
   input  wire logic [1:0] length_sel_in,
   // Samples.
   input  wire logic       sample_valid_in,
   input  wire logic [7:0] sample_amp_in,
   // Result.
   output logic            avg_valid_out,
   output logic [7:0]      avg_out
);

   gain_loop_pkg::averager_state_t st_q;
   gain_loop_pkg::averager_state_t st_d;
   logic [2:0]                     shift_amt;
   logic [6:0]                     length_smp;
   logic [13:0]                    new_sum;
   logic [13:0]                    shifted;

   //////////////////////////////////////////////////////////////////////////////
   // Length 8 << sel gives 8, 16, 32 or 64; a power of two keeps the divide a shift.
   always_comb
   begin
      st_d       = st_q;
      st_d.valid = 1'b0;
      shift_amt  = 3'(`AVG_BASE_LOG2) + {1'b0, length_sel_in};
      length_smp = 7'(7'h01 << shift_amt);
      new_sum    = st_q.sum + {6'h00, sample_amp_in};
      shifted    = new_sum >> shift_amt;
      if (clear_in)
      begin
         st_d.sum   = 14'h0000;
         st_d.count = 7'h00;
      end
      else if (sample_valid_in)
      begin
         if (7'(st_q.count + 7'h01) >= length_smp)
         begin
            st_d.average = shifted[7:0];
            st_d.valid   = 1'b1;
            st_d.sum     = 14'h0000;
            st_d.count   = 7'h00;
         end
         else
         begin
            st_d.sum   = new_sum;
            st_d.count = 7'(st_q.count + 7'h01);
         end
      end
   end

   // State register.
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign avg_valid_out = st_q.valid;
   assign avg_out       = st_q.average;

endmodule

// ==== core/rx_gain_control_loop.sv ====
// Receiver gain control loop with its control registers and absolute carrier sense.
`timescale 1ns/10ps
`include "gain_loop_regs.svh"

module rx_gain_control_loop
(
   // Clock and reset.
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   // Register port.
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [5:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic [7:0]      reg_rdata_out,
   // Channel filter samples and packet events.
   input  wire logic       sample_valid_in,
   input  wire logic [7:0] sample_amp_in,
   input  wire logic       sync_found_in,
   input  wire logic       rx_restart_in,
   // Gain and carrier sense.
   output logic [2:0]      analog_reduction_out,
   output logic [2:0]      digital_reduction_out,
   output logic            carrier_sense_out
);

   typedef struct packed {
      gain_loop_pkg::loop_state_t state;
      gain_loop_pkg::step_dir_t   last_dir;
      logic [5:0]                 wait_cnt;
      logic [7:0]                 gain_ctrl;
      logic [3:0]                 abs_thr;
      logic [2:0]                 target;
      logic [5:0]                 manual_gain;
      logic [2:0]                 analog_red;
      logic [2:0]                 digital_red;
      logic                       sync_seen;
      logic                       cs;
      logic [7:0]                 rdata;
   } loop_regs_t;

   loop_regs_t  r_q;
   loop_regs_t  r_d;
   logic        avg_valid;
   logic [7:0]  avg_amp;
   logic        avg_clear;
   logic        avg_sample;
   logic [7:0]  target_db;
   logic [9:0]  deviation;
   logic [9:0]  up_limit;
   logic [9:0]  dn_limit;
   logic [9:0]  level_db;
   logic [9:0]  thr_db;
   logic [3:0]  total_red;
   logic        too_strong;
   logic        too_weak;
   logic        analog_free;
   logic        digital_free;
   logic [5:0]  wait_len;

   //////////////////////////////////////////////////////////////////////////////
   // Averaging feeds only while accumulating, so samples taken during the
   // settling wait never reach an average.
   assign avg_sample = sample_valid_in && (r_q.state == gain_loop_pkg::ST_ACCUM);

   sample_averager u_averager
   (
      .ref_clk_in      (ref_clk_in),
      .reset_n_in      (reset_n_in),
      .clear_in        (avg_clear),
      .length_sel_in   (r_q.gain_ctrl[`FILT_FIELD]),
      .sample_valid_in (avg_sample),
      .sample_amp_in   (sample_amp_in),
      .avg_valid_out   (avg_valid),
      .avg_out         (avg_amp)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Target level and dead zone lookups.
   always_comb
   begin
      case (r_q.target)
         3'h0:    target_db = `TARGET_DB_0;
         3'h1:    target_db = `TARGET_DB_1;
         3'h2:    target_db = `TARGET_DB_2;
         3'h3:    target_db = `TARGET_DB_3;
         3'h4:    target_db = `TARGET_DB_4;
         3'h5:    target_db = `TARGET_DB_5;
         3'h6:    target_db = `TARGET_DB_6;
         default: target_db = `TARGET_DB_7;
      endcase
      case (r_q.gain_ctrl[`HYST_FIELD])
         2'h0:
         begin
            up_limit = `DZ_UP_0;
            dn_limit = `DZ_DN_0;
         end
         2'h1:
         begin
            up_limit = `DZ_UP_1;
            dn_limit = `DZ_DN_1;
         end
         2'h2:
         begin
            up_limit = `DZ_UP_2;
            dn_limit = `DZ_DN_2;
         end
         default:
         begin
            up_limit = `DZ_UP_3;
            dn_limit = `DZ_DN_3;
         end
      endcase
      // Reversing direction needs an extra margin so the loop cannot chatter.
      if (r_q.last_dir == gain_loop_pkg::DIR_UP)
         up_limit = up_limit + `REVERSAL_MARGIN_DB;
      if (r_q.last_dir == gain_loop_pkg::DIR_DOWN)
         dn_limit = dn_limit + `REVERSAL_MARGIN_DB;
   end

   //////////////////////////////////////////////////////////////////////////////
   // Deviation and level estimate, all in signed 10-bit dB.
   assign deviation  = {2'b00, avg_amp} - {2'b00, target_db};
   assign too_strong = $signed(deviation) > $signed(up_limit);
   assign too_weak   = $signed(deviation) < -$signed(dn_limit);
   assign total_red  = {1'b0, r_q.analog_red} + {1'b0, r_q.digital_red};
   // Gain taken out is added back so the level reads as the antenna level.
   assign level_db   = {2'b00, avg_amp} + 10'({6'h00, total_red} * {6'h00, `GAIN_STEP_DB});
   // Sign extension turns 1001..1111 into -7..-1 dB and 0001..0111 into +1..+7 dB.
   assign thr_db     = {2'b00, target_db} + {{6{r_q.abs_thr[3]}}, r_q.abs_thr};
   assign wait_len   = 6'({4'h0, r_q.gain_ctrl[`WAIT_FIELD]} + 6'h01) * `WAIT_UNIT_SAMPLES;

   //////////////////////////////////////////////////////////////////////////////
   // Which stages may move under the current hold setting.
   always_comb
   begin
      case (r_q.gain_ctrl[`HOLD_FIELD])
         `HOLD_NONE:
         begin
            analog_free  = 1'b1;
            digital_free = 1'b1;
         end
         `HOLD_ON_SYNC:
         begin
            analog_free  = !r_q.sync_seen;
            digital_free = !r_q.sync_seen;
         end
         `HOLD_ANALOG:
         begin
            analog_free  = 1'b0;
            digital_free = 1'b1;
         end
         default:
         begin
            analog_free  = 1'b0;
            digital_free = 1'b0;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////
   // Next state: registers, loop sequencing, gain steps and carrier sense.
   always_comb
   begin
      r_d       = r_q;
      avg_clear = 1'b0;

      // Register writes and registered read data.
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            `TARGET_ADDR:      r_d.target      = reg_wdata_in[`TARGET_FIELD];
            `ABS_THR_ADDR:     r_d.abs_thr     = reg_wdata_in[`THR_FIELD];
            `GAIN_CTRL_ADDR:   r_d.gain_ctrl   = reg_wdata_in;
            `MANUAL_GAIN_ADDR: r_d.manual_gain = {reg_wdata_in[`MAN_ANALOG_FIELD], reg_wdata_in[`MAN_DIGITAL_FIELD]};
            default:           r_d.gain_ctrl   = r_q.gain_ctrl;
         endcase
      end
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            `TARGET_ADDR:      r_d.rdata = {5'h00, r_q.target};
            `ABS_THR_ADDR:     r_d.rdata = {4'h0, r_q.abs_thr};
            `GAIN_CTRL_ADDR:   r_d.rdata = r_q.gain_ctrl;
            `MANUAL_GAIN_ADDR: r_d.rdata = {2'b00, r_q.analog_red, r_q.digital_red};
            default:           r_d.rdata = 8'h00;
         endcase
      end

      // Sync capture; a sync in the restart cycle still counts.
      if (rx_restart_in)
         r_d.sync_seen = 1'b0;
      if (sync_found_in)
         r_d.sync_seen = 1'b1;

      case (r_q.state)
         gain_loop_pkg::ST_ACCUM:
         begin
            if (avg_valid)
            begin
               if (too_strong && analog_free && (r_q.analog_red != `GAIN_MAX_STEP))
               begin
                  r_d.analog_red = 3'(r_q.analog_red + 3'h1);
                  r_d.last_dir   = gain_loop_pkg::DIR_DOWN;
               end
               else if (too_strong && digital_free && (r_q.digital_red != `GAIN_MAX_STEP))
               begin
                  r_d.digital_red = 3'(r_q.digital_red + 3'h1);
                  r_d.last_dir    = gain_loop_pkg::DIR_DOWN;
               end
               else if (too_weak && digital_free && (r_q.digital_red != `GAIN_MIN_STEP))
               begin
                  r_d.digital_red = 3'(r_q.digital_red - 3'h1);
                  r_d.last_dir    = gain_loop_pkg::DIR_UP;
               end
               else if (too_weak && analog_free && (r_q.analog_red != `GAIN_MIN_STEP))
               begin
                  r_d.analog_red = 3'(r_q.analog_red - 3'h1);
                  r_d.last_dir   = gain_loop_pkg::DIR_UP;
               end
               // Any step starts the settling wait and drops the partial average.
               if ((r_d.analog_red != r_q.analog_red) || (r_d.digital_red != r_q.digital_red))
               begin
                  r_d.state    = gain_loop_pkg::ST_WAIT;
                  r_d.wait_cnt = 6'h00;
                  avg_clear    = 1'b1;
               end
            end
         end
         gain_loop_pkg::ST_WAIT:
         begin
            avg_clear = 1'b1;
            if (sample_valid_in)
            begin
               if (6'(r_q.wait_cnt + 6'h01) >= wait_len)
                  r_d.state = gain_loop_pkg::ST_ACCUM;
               else
                  r_d.wait_cnt = 6'(r_q.wait_cnt + 6'h01);
            end
         end
         default:
         begin
            r_d.state = gain_loop_pkg::ST_ACCUM;
         end
      endcase

      // Under full hold, software owns both stages.
      if (r_q.gain_ctrl[`HOLD_FIELD] == `HOLD_ALL)
      begin
         r_d.analog_red  = r_q.manual_gain[`MAN_ANALOG_FIELD];
         r_d.digital_red = r_q.manual_gain[`MAN_DIGITAL_FIELD];
         r_d.state       = gain_loop_pkg::ST_ACCUM;
      end

      // Carrier sense follows each fresh average; disabled code forces it low.
      if (r_q.abs_thr == `THR_DISABLED)
         r_d.cs = 1'b0;
      else if (avg_valid)
         r_d.cs = $signed(level_db) >= $signed(thr_db);
   end

   // State register.
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         r_q             <= '0;
         r_q.gain_ctrl   <= `GAIN_CTRL_RESET;
         r_q.abs_thr     <= `ABS_THR_RESET;
         r_q.target      <= `TARGET_RESET;
         r_q.manual_gain <= `MANUAL_GAIN_RESET;
      end
      else
         r_q <= r_d;
   end

   assign reg_rdata_out         = r_q.rdata;
   assign analog_reduction_out  = r_q.analog_red;
   assign digital_reduction_out = r_q.digital_red;
   assign carrier_sense_out     = r_q.cs;

endmodule

// ==== bench/rx_gain_control_loop_properties.sv ====
// Port-level assertions and covers for the receiver gain control loop.
`timescale 1ns/10ps
`include "gain_loop_regs.svh"

module gain_loop_checker
(
   // Clock and reset.
   input wire logic       ref_clk_in,
   input wire logic       reset_n_in,
   // Register port.
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   // Gain and carrier sense.
   input wire logic [2:0] analog_reduction_out,
   input wire logic [2:0] digital_reduction_out,
   input wire logic       carrier_sense_out
);
   logic [7:0] ctrl_q;
   logic [1:0] man_q;
   wire  logic man_wr = reg_wr_in && reg_addr_in == `MANUAL_GAIN_ADDR;
   wire  logic [1:0] hold = ctrl_q[`HOLD_FIELD];

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   ////////////////////////////////////////////////////////////////////////
   // Shadow of the control register; hold modes are invisible at the ports otherwise.
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
      if (!reset_n_in)
      begin
         ctrl_q <= `GAIN_CTRL_RESET;
         man_q  <= 2'h0;
      end
      else
      begin
         if (reg_wr_in && reg_addr_in == `GAIN_CTRL_ADDR)
            ctrl_q <= reg_wdata_in;
         man_q <= {man_q[0], man_wr};
      end

   ////////////////////////////////////////////////////////////////////////
   // Assertions tie outputs to the register writes and modes that cause them.
   chk_thr_off: assert property (
      reg_wr_in && reg_addr_in == `ABS_THR_ADDR && reg_wdata_in[3:0] == `THR_DISABLED |-> ##2 !carrier_sense_out)
      else $error("carrier sense high with threshold disabled");
   chk_manual_gain: assert property (
      man_wr && hold == 2'h3 |-> ##2 analog_reduction_out == $past(reg_wdata_in[5:3], 2)
      && digital_reduction_out == $past(reg_wdata_in[2:0], 2))
      else $error("manual gain not applied");
   chk_all_frozen: assert property (
      hold == 2'h3 && $past(hold) == 2'h3 && !man_wr && man_q == 2'h0
      |=> $stable(analog_reduction_out) && $stable(digital_reduction_out))
      else $error("gain moved while fully held");
   chk_analog_held: assert property (
      hold == 2'h2 && $past(hold) == 2'h2 |=> $stable(analog_reduction_out))
      else $error("analog gain moved while held");
   chk_step_size: assert property (
      hold != 2'h3 && $past(hold) != 2'h3 |-> analog_reduction_out == $past(analog_reduction_out)
      || analog_reduction_out == $past(analog_reduction_out) + 3'h1
      || analog_reduction_out == $past(analog_reduction_out) - 3'h1)
      else $error("analog gain jumped by more than one step");
   chk_rdata_keep: assert property (
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");
   chk_unmapped_zero: assert property (
      reg_rd_in && !(reg_addr_in inside {`TARGET_ADDR, `ABS_THR_ADDR, `GAIN_CTRL_ADDR, `MANUAL_GAIN_ADDR})
      |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   chk_ctrl_read: assert property (
      reg_rd_in && reg_addr_in == `GAIN_CTRL_ADDR |=> reg_rdata_out == $past(ctrl_q))
      else $error("control register read back wrong");

   // Covers for the main scenarios.
   cover property (man_wr && hold == 2'h3);
   cover property ($rose(carrier_sense_out));
   cover property (hold == 2'h2 && $changed(digital_reduction_out));
endmodule

bind rx_gain_control_loop gain_loop_checker chk
(
   .ref_clk_in            (ref_clk_in),
   .reset_n_in            (reset_n_in),
   .reg_wr_in             (reg_wr_in),
   .reg_rd_in             (reg_rd_in),
   .reg_addr_in           (reg_addr_in),
   .reg_wdata_in          (reg_wdata_in),
   .reg_rdata_out         (reg_rdata_out),
   .analog_reduction_out  (analog_reduction_out),
   .digital_reduction_out (digital_reduction_out),
   .carrier_sense_out     (carrier_sense_out)
);

// ==== bench/rx_gain_control_loop_tb.sv ====
// Self-checking testbench of the receiver gain control loop.
`timescale 1ns/10ps
`include "gain_loop_regs.svh"

module rx_gain_control_loop_tb;
   logic       ref_clk_in      = 1'b0;
   logic       reset_n_in      = 1'b0;
   logic       reg_wr_in       = 1'b0;
   logic       reg_rd_in       = 1'b0;
   logic [5:0] reg_addr_in     = 6'h00;
   logic [7:0] reg_wdata_in    = 8'h00;
   logic       sample_valid_in = 1'b0;
   logic [7:0] sample_amp_in   = 8'h00;
   logic       sync_found_in   = 1'b0;
   logic       rx_restart_in   = 1'b0;
   logic [7:0] reg_rdata_out;
   logic [2:0] analog_reduction_out;
   logic [2:0] digital_reduction_out;
   logic       carrier_sense_out;
   int         err_count       = 0;
   int         checks          = 0;
   logic [3:0] thr_tab [3]     = '{4'h7, 4'hF, 4'h6};
   logic       cs_tab [3]      = '{1'b0, 1'b1, 1'b1};

   // Free-running 50 MHz clock.
   always #10 ref_clk_in = ~ref_clk_in;

   rx_gain_control_loop dut
   (
      .ref_clk_in            (ref_clk_in),
      .reset_n_in            (reset_n_in),
      .reg_wr_in             (reg_wr_in),
      .reg_rd_in             (reg_rd_in),
      .reg_addr_in           (reg_addr_in),
      .reg_wdata_in          (reg_wdata_in),
      .reg_rdata_out         (reg_rdata_out),
      .sample_valid_in       (sample_valid_in),
      .sample_amp_in         (sample_amp_in),
      .sync_found_in         (sync_found_in),
      .rx_restart_in         (rx_restart_in),
      .analog_reduction_out  (analog_reduction_out),
      .digital_reduction_out (digital_reduction_out),
      .carrier_sense_out     (carrier_sense_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shared comparison, verdict and access tasks.
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr_reg(input logic [5:0] addr, input logic [7:0] data);
      @(posedge ref_clk_in);
      #1 reg_wr_in = 1'b1;
      reg_addr_in = addr;
      reg_wdata_in = data;
      @(posedge ref_clk_in);
      #1 reg_wr_in = 1'b0;
   endtask

   task automatic rd_chk(input logic [5:0] addr, input logic [7:0] exp);
      @(posedge ref_clk_in);
      #1 reg_rd_in = 1'b1;
      reg_addr_in = addr;
      @(posedge ref_clk_in);
      #1 reg_rd_in = 1'b0;
      check("read data", reg_rdata_out, exp);
   endtask

   // Samples go one per cycle; the two-edge output latency is covered by the tail.
   task automatic feed(input int n, input logic [7:0] amp);
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk_in);
         #1 sample_valid_in = 1'b1;
         sample_amp_in = amp;
      end
      @(posedge ref_clk_in);
      #1 sample_valid_in = 1'b0;
      repeat (3) @(posedge ref_clk_in);
      #1;
   endtask

   task automatic gain_chk(input logic [2:0] a, input logic [2:0] d);
      check("analog reduction", {5'h00, analog_reduction_out}, {5'h00, a});
      check("digital reduction", {5'h00, digital_reduction_out}, {5'h00, d});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // A stuck run is cut short and counted as a mismatch.
   initial
   begin
      repeat (20000) @(posedge ref_clk_in);
      err_count++;
      complete_run();
   end

   // Main sequence: target 33 dB, dead zone 3/2 dB, waits of 8 samples unless stated.
   initial
   begin
      repeat (6) @(posedge ref_clk_in);
      #1 reset_n_in = 1'b1;
      rd_chk(`GAIN_CTRL_ADDR, 8'h91);
      rd_chk(`ABS_THR_ADDR, 8'h00);
      rd_chk(`TARGET_ADDR, 8'h03);
      rd_chk(`MANUAL_GAIN_ADDR, 8'h00);
      rd_chk(6'h3F, 8'h00);
      wr_reg(`GAIN_CTRL_ADDR, 8'h80);
      rd_chk(`GAIN_CTRL_ADDR, 8'h80);
      feed(8, 8'h28);
      gain_chk(3'h1, 3'h0);
      feed(8, 8'h28);
      feed(8, 8'h28);
      gain_chk(3'h2, 3'h0);
      feed(8, 8'h28);
      feed(8, 8'h21);
      gain_chk(3'h2, 3'h0);
      check("carrier sense", {7'h00, carrier_sense_out}, 8'h01);
      wr_reg(`ABS_THR_ADDR, 8'h08);
      repeat (2) @(posedge ref_clk_in);
      #1 check("carrier sense", {7'h00, carrier_sense_out}, 8'h00);
      // Level is 39 dB against 40, 32 and 39 dB.
      for (int k = 0; k < 3; k++)
      begin
         wr_reg(`ABS_THR_ADDR, {4'h0, thr_tab[k]});
         feed(8, 8'h21);
         check("carrier sense", {7'h00, carrier_sense_out}, {7'h00, cs_tab[k]});
      end
      wr_reg(`GAIN_CTRL_ADDR, 8'h88);
      feed(8, 8'h28);
      gain_chk(3'h2, 3'h1);
      feed(8, 8'h28);
      wr_reg(`GAIN_CTRL_ADDR, 8'h84);
      @(posedge ref_clk_in);
      #1 sync_found_in = 1'b1;
      @(posedge ref_clk_in);
      #1 sync_found_in = 1'b0;
      feed(8, 8'h28);
      gain_chk(3'h2, 3'h1);
      @(posedge ref_clk_in);
      #1 rx_restart_in = 1'b1;
      @(posedge ref_clk_in);
      #1 rx_restart_in = 1'b0;
      feed(8, 8'h28);
      gain_chk(3'h3, 3'h1);
      feed(8, 8'h28);
      wr_reg(`GAIN_CTRL_ADDR, 8'h8C);
      wr_reg(`MANUAL_GAIN_ADDR, 8'h2A);
      repeat (2) @(posedge ref_clk_in);
      #1 gain_chk(3'h5, 3'h2);
      rd_chk(`MANUAL_GAIN_ADDR, 8'h2A);
      feed(8, 8'h28);
      gain_chk(3'h5, 3'h2);
      wr_reg(`GAIN_CTRL_ADDR, 8'h80);
      feed(8, 8'h14);
      gain_chk(3'h5, 3'h1);
      feed(8, 8'h14);
      wr_reg(`GAIN_CTRL_ADDR, 8'h81);
      feed(8, 8'h14);
      gain_chk(3'h5, 3'h1);
      feed(8, 8'h14);
      gain_chk(3'h5, 3'h0);
      // Target 40 dB, large hysteresis: 46 dB sits inside 5 dB plus the reversal margin, 47 dB does not.
      wr_reg(`TARGET_ADDR, 8'h06);
      rd_chk(`TARGET_ADDR, 8'h06);
      wr_reg(`GAIN_CTRL_ADDR, 8'hF2);
      feed(32, 8'h2E);
      feed(32, 8'h2E);
      gain_chk(3'h5, 3'h0);
      feed(32, 8'h2F);
      gain_chk(3'h6, 3'h0);
      // A 32-sample wait and a 32-sample average leave one sample short of the next step.
      feed(31, 8'h2F);
      feed(32, 8'h2F);
      gain_chk(3'h6, 3'h0);
      feed(1, 8'h2F);
      gain_chk(3'h7, 3'h0);
      // Low hysteresis, 16-sample wait after a step down: 37 dB is past 1 dB plus margin, so gain comes back.
      wr_reg(`GAIN_CTRL_ADDR, 8'h50);
      feed(16, 8'h28);
      feed(8, 8'h25);
      gain_chk(3'h6, 3'h0);
      // No hysteresis, 24-sample wait: 43 dB is past 1 dB plus margin.
      wr_reg(`GAIN_CTRL_ADDR, 8'h20);
      feed(23, 8'h2B);
      feed(8, 8'h2B);
      gain_chk(3'h6, 3'h0);
      feed(1, 8'h2B);
      gain_chk(3'h7, 3'h0);
      complete_run();
   end
endmodule
